// >>> src/sere_top.sv
// read side of a two-wire serial memory slave with a streamed preload port
// assumes scl/sda/device select come from pins; write busy comes from logic on i_clk
`timescale 1ns/1ps
`include "sere_consts.svh"
module sere_top
   import sere_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'h5,   // value is arbitrary
   parameter int         AW       = `SERE_ADDR_W,
   parameter int         DEPTH    = `SERE_FIFO_DEPTH
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   input  wire logic [2:0] i_device_select_inputs,
   input  wire logic       i_write_busy,
   input  wire logic       i_ld_valid,
   input  wire logic [7:0] i_ld_data,
   output logic            o_ld_ready,
   output logic [AW-1:0]   o_addr_cnt
);
   logic [7:0]    mem [2**AW];
   logic [7:0]    mem_q;
   logic          scl_s1_reg;
   logic          scl_s2_reg;
   logic          scl_s3_reg;
   logic          sda_s1_reg;
   logic          sda_s2_reg;
   logic          sda_s3_reg;
   logic [2:0]    sel_s1_reg;
   logic [2:0]    sel_s2_reg;
   logic          rise;
   logic          fall;
   logic          start;
   logic          stop;
   sere_state_t   st_reg;
   sere_state_t   st_next;
   logic [3:0]    bit_reg;
   logic [3:0]    bit_next;
   logic [7:0]    sh_reg;
   logic [7:0]    sh_next;
   logic [`SERE_HI_BITS-1:0] hi_reg;
   logic [`SERE_HI_BITS-1:0] hi_next;
   logic [AW-1:0] addr_reg;
   logic [AW-1:0] addr_next;
   logic [AW-1:0] ld_ptr_reg;
   logic [AW-1:0] ld_ptr_next;
   logic          rw_reg;
   logic          rw_next;
   logic          oe_reg;
   logic          oe_next;
   logic          fifo_valid;
   logic [7:0]    fifo_data;
   logic          drain;
   logic          match;

   sere_fifo #(
      .W  (8),
      .D  (DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (i_ld_valid),
      .i_in_data   (i_ld_data),
      .o_in_ready  (o_ld_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_data),
      .i_out_ready (drain)
   );

   // pin synchronisers; stage one feeds stage two only
   always_ff @(posedge i_clk)
   begin
      scl_s1_reg <= i_scl;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= i_sda;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      sel_s1_reg <= i_device_select_inputs;
      sel_s2_reg <= sel_s1_reg;
   end

   assign rise  = scl_s2_reg & ~scl_s3_reg;
   assign fall  = ~scl_s2_reg & scl_s3_reg;
   assign start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
   assign stop  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
   assign mem_q = mem[addr_reg];
   // preload drains only while the engine is idle and write busy is low, so a full fifo stalls the source
   assign drain = (st_reg == SERE_IDLE) & ~i_write_busy;

   assign match = (sh_reg[`SERE_TYPE_MSB:`SERE_TYPE_LSB] == DEV_TYPE)
                & (sh_reg[`SERE_SEL_MSB:`SERE_SEL_LSB] == sel_s2_reg)
                & ~i_write_busy;

   always_comb
   begin
      st_next     = st_reg;
      bit_next    = bit_reg;
      sh_next     = sh_reg;
      hi_next     = hi_reg;
      addr_next   = addr_reg;
      rw_next     = rw_reg;
      oe_next     = oe_reg;
      ld_ptr_next = ld_ptr_reg;
      if (drain & fifo_valid)
      begin
         ld_ptr_next = ld_ptr_reg + 1'b1;
      end
      if (stop)
      begin
         st_next = SERE_IDLE;
         oe_next = 1'b0;
      end
      else if (start)
      begin
         oe_next  = 1'b0;
         bit_next = 4'h0;
         st_next  = i_write_busy ? SERE_IDLE : SERE_DEV;
      end
      else
      begin
         case (st_reg)
            SERE_IDLE:
            begin
               st_next = SERE_IDLE;
            end
            SERE_DEV, SERE_HI, SERE_LO:
            begin
               if (rise)
               begin
                  sh_next  = {sh_reg[6:0], sda_s2_reg};
                  bit_next = bit_reg + 4'h1;
               end
               else if (fall && bit_reg == `SERE_BYTE_BITS)
               begin
                  bit_next = 4'h0;
                  oe_next  = 1'b1;
                  if (st_reg == SERE_DEV)
                  begin
                     rw_next = sh_reg[`SERE_RW_BIT];
                     oe_next = match;
                     st_next = match ? SERE_ACK_DEV : SERE_IDLE;
                  end
                  else if (st_reg == SERE_HI)
                  begin
                     hi_next = sh_reg[`SERE_HI_BITS-1:0];
                     st_next = SERE_ACK_HI;
                  end
                  else
                  begin
                     addr_next = {hi_reg, sh_reg};
                     st_next   = SERE_ACK_LO;
                  end
               end
            end
            SERE_ACK_DEV, SERE_MACK_OK:
            begin
               if (fall)
               begin
                  if (rw_reg || st_reg == SERE_MACK_OK)
                  begin
                     sh_next  = mem_q;
                     oe_next  = ~mem_q[7];
                     bit_next = 4'h1;
                     st_next  = SERE_TX;
                  end
                  else
                  begin
                     oe_next  = 1'b0;
                     bit_next = 4'h0;
                     st_next  = SERE_HI;
                  end
               end
            end
            SERE_ACK_HI:
            begin
               if (fall)
               begin
                  oe_next = 1'b0;
                  st_next = SERE_LO;
               end
            end
            SERE_ACK_LO:
            begin
               // a repeated start follows; further write data is not taken here
               if (fall)
               begin
                  oe_next = 1'b0;
                  st_next = SERE_IDLE;
               end
            end
            SERE_TX:
            begin
               if (fall)
               begin
                  if (bit_reg == `SERE_BYTE_BITS)
                  begin
                     oe_next   = 1'b0;
                     addr_next = addr_reg + 1'b1;
                     st_next   = SERE_MACK;
                  end
                  else
                  begin
                     oe_next  = ~sh_reg[6];
                     sh_next  = {sh_reg[6:0], 1'b0};
                     bit_next = bit_reg + 4'h1;
                  end
               end
            end
            SERE_MACK:
            begin
               if (rise)
               begin
                  st_next = sda_s2_reg ? SERE_IDLE : SERE_MACK_OK;
               end
            end
            default:
            begin
               st_next = SERE_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         st_reg     <= SERE_IDLE;
         bit_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         hi_reg     <= '0;
         addr_reg   <= `SERE_ADDR_RST;
         ld_ptr_reg <= `SERE_ADDR_RST;
         rw_reg     <= 1'b0;
         oe_reg     <= 1'b0;
      end
      else
      begin
         st_reg     <= st_next;
         bit_reg    <= bit_next;
         sh_reg     <= sh_next;
         hi_reg     <= hi_next;
         addr_reg   <= addr_next;
         ld_ptr_reg <= ld_ptr_next;
         rw_reg     <= rw_next;
         oe_reg     <= oe_next;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (drain & fifo_valid)
      begin
         mem[ld_ptr_reg] <= fifo_data;
      end
   end

   // open drain: the pin is only ever pulled low
   always_ff @(posedge i_clk)
   begin
      o_sda_o <= 1'b0;
   end

   assign o_sda_oe   = oe_reg;
   assign o_addr_cnt = addr_reg;
endmodule

// >>> src/sere_consts.svh
// constants of the serial memory read engine: field positions, widths, reset values
// assumes inclusion by bare name from the package and sere_top
`ifndef SERE_CONSTS_SVH
`define SERE_CONSTS_SVH
`define SERE_ADDR_W      13
`define SERE_HI_BITS     5
`define SERE_BYTE_BITS   4'h8
`define SERE_TYPE_MSB    7
`define SERE_TYPE_LSB    4
`define SERE_SEL_MSB     3
`define SERE_SEL_LSB     1
`define SERE_RW_BIT      0
`define SERE_ADDR_RST    13'h0000
`define SERE_FIFO_DEPTH  16
`endif

// >>> src/sere_pkg.sv
// types of the serial memory read engine
// assumes sere_consts.svh is on the include path
`include "sere_consts.svh"
package sere_pkg;
   typedef enum logic [3:0] {
      SERE_IDLE    = 4'h0,
      SERE_DEV     = 4'h1,
      SERE_ACK_DEV = 4'h2,
      SERE_HI      = 4'h3,
      SERE_ACK_HI  = 4'h4,
      SERE_LO      = 4'h5,
      SERE_ACK_LO  = 4'h6,
      SERE_TX      = 4'h7,
      SERE_MACK    = 4'h8,
      SERE_MACK_OK = 4'h9
   } sere_state_t;
endpackage

// >>> src/sere_fifo.sv
// parameterised fifo with valid/ready on both sides and a registered ready
// assumes depth is a power of two and one clock domain
`timescale 1ns/1ps
module sere_fifo #(
   parameter int W  = 8,
   parameter int D  = 16,
   parameter int AW = $clog2(D)
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] wr_next;
   logic [AW-1:0] rd_reg;
   logic [AW-1:0] rd_next;
   logic [AW:0]   cnt_reg;
   logic [AW:0]   cnt_next;
   logic          ready_reg;
   logic          ready_next;
   logic          push;
   logic          pop;

   always_comb
   begin
      push       = i_in_valid & ready_reg;
      pop        = i_out_ready & (cnt_reg != '0);
      wr_next    = push ? wr_reg + 1'b1 : wr_reg;
      rd_next    = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next   = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      ready_next = (cnt_next != (AW+1)'(D));
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         cnt_reg   <= '0;
         ready_reg <= 1'b0;
      end
      else
      begin
         wr_reg    <= wr_next;
         rd_reg    <= rd_next;
         cnt_reg   <= cnt_next;
         ready_reg <= ready_next;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wr_reg] <= i_in_data;
      end
   end

   assign o_in_ready  = ready_reg;
   assign o_out_valid = (cnt_reg != '0);
   assign o_out_data  = mem[rd_reg];
endmodule

// >>> sim/sere_top_assertions.sv
// pin checker for the serial memory read engine
// assumes bind onto sere_top, scl phases of 12 clk or more
`timescale 1ns/1ps
module sere_top_assertions #(
   parameter int AW = 13
) (
   input wire logic          i_clk,
   input wire logic          i_rst,
   input wire logic          i_scl,
   input wire logic          i_sda,
   input wire logic          o_sda_o,
   input wire logic          o_sda_oe,
   input wire logic          i_write_busy,
   input wire logic [AW-1:0] o_addr_cnt
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [7:0] run_reg;
   logic [7:0] run_next;
   logic       oe_reg;
   // cycles since the sda enable last moved
   always_comb
   begin
      run_next = (run_reg == 8'hff) ? run_reg : run_reg + 8'h01;
      if (o_sda_oe != oe_reg)
         run_next = 8'h00;
   end
   always_ff @(posedge i_clk)
   begin
      run_reg <= i_rst ? 8'hff : run_next;
      oe_reg  <= i_rst ? 1'b0 : o_sda_oe;
   end
   sequence start_s;
      i_scl && $past(i_scl) && $fell(i_sda);
   endsequence
   sequence stop_s;
      i_scl && $past(i_scl) && $rose(i_sda);
   endsequence
   start_release_a: assert property (start_s |=> !o_sda_oe [*8])
      else $error("sda driven after start");
   stop_idle_a: assert property (stop_s |-> ##[0:3] !o_sda_oe ##1 $stable(o_sda_oe) [*8])
      else $error("sda driven after stop");
   oe_on_low_a: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
      else $error("sda moved outside scl low");
   scl_high_a: assert property (i_scl && $past(i_scl, 4) |-> $stable(o_sda_oe))
      else $error("sda moved in scl high");
   drive_zero_a: assert property (o_sda_oe |-> !o_sda_o)
      else $error("sda driven high");
   busy_no_ack_a: assert property (i_write_busy && $past(i_write_busy, 8) |-> !$rose(o_sda_oe))
      else $error("ack while busy");
   bit_hold_a: assert property ((o_sda_oe != oe_reg) |-> run_reg >= 8'd20)
      else $error("sda bit too short");
   reset_vals_a: assert property (disable iff (1'b0) i_rst |=> !o_sda_oe && o_addr_cnt == {AW{1'b0}})
      else $error("bad reset values");
endmodule
bind sere_top sere_top_assertions #(.AW(AW)) u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_write_busy(i_write_busy), .o_addr_cnt(o_addr_cnt));

// >>> sim/sere_master.sv
// two-wire bus master model: drives scl, pulls sda low
// assumes a pull-up on sda in the bench; scl period 25 clk
`timescale 1ns/1ps
module sere_master (
   input  wire logic  i_clk,
   input  wire logic  i_sda,
   output logic       o_scl,
   output logic       o_oe,
   output logic [7:0] o_rd_data
);
   event got;
   initial
   begin
      o_scl = 1'b1;
      o_oe = 1'b0;
      o_rd_data = 8'h00;
   end
   task automatic w(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // sda set in the low phase, sampled in the high phase
   task automatic clk_bit(input logic b, output logic s);
      o_scl <= 1'b0;
      w(6);
      o_oe <= ~b;
      w(7);
      o_scl <= 1'b1;
      w(6);
      s = i_sda;
      w(6);
   endtask
   // sda falls (start) or rises (stop) while scl is high
   task automatic edge_cond(input logic fall);
      o_scl <= 1'b0;
      w(6);
      o_oe <= ~fall;
      w(7);
      o_scl <= 1'b1;
      w(6);
      o_oe <= fall;
      w(6);
   endtask
   task automatic wb(input logic [7:0] b, output logic nack);
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], nack);
      clk_bit(1'b1, nack);
   endtask
   task automatic rb(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, d[i]);
      clk_bit(last, s);
      o_rd_data = d;
      -> got;
   endtask
endmodule

// >>> sim/sere_top_test.sv
// bench for sere_top: preload stream, write busy and reads over the bus
// assumes sere_master as bus partner and a pull-up on sda
`timescale 1ns/1ps
module sere_top_test;
   localparam logic [3:0] DEV = 4'h5; // value is arbitrary
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_write_busy = 1'b0;
   logic        i_ld_valid = 1'b0;
   logic [7:0]  i_ld_data;
   logic [2:0]  sel;
   logic [31:0] rnd = 32'h8a3dc23e;
   logic [12:0] ptr = 13'h0000;
   logic [12:0] cnt = 13'h0000;
   logic [7:0]  mem [0:8191];
   logic [7:0]  exp_q [$];
   logic        scl, m_oe, sda_oe, sda_o, ld_ready, s;
   logic [12:0] addr_cnt;
   int          mismatches = 0;
   int          cmp_count = 0;
   wire         sda = ~(m_oe | (sda_oe & ~sda_o));
   always #2.5 i_clk = ~i_clk;
   sere_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_oe(m_oe), .o_rd_data());
   sere_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_device_select_inputs(sel), .i_write_busy(i_write_busy), .i_ld_valid(i_ld_valid),
      .i_ld_data(i_ld_data), .o_ld_ready(ld_ready), .o_addr_cnt(addr_cnt));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic cmp(input string n, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic push(input logic [7:0] b);
      i_ld_valid <= 1'b1;
      i_ld_data <= b;
      @(posedge i_clk);
      while (ld_ready !== 1'b1)
         @(posedge i_clk);
      mem[ptr] = b;
      ptr++;
   endtask
   task automatic seek(input logic [7:0] hi, input logic [7:0] lo);
      m.edge_cond(1'b1);
      m.wb({DEV, sel, 1'b0}, s);
      cmp("wr ack", s, 1'b0);
      m.wb(hi, s);
      cmp("hi ack", s, 1'b0);
      m.wb(lo, s);
      cmp("lo ack", s, 1'b0);
      cnt = {hi[4:0], lo};
   endtask
   // start (or repeated start), then n words from the counter
   task automatic rd(input int n);
      logic [7:0] d;
      m.edge_cond(1'b1);
      m.wb({DEV, sel, 1'b1}, s);
      cmp("rd ack", s, 1'b0);
      for (int k = 0; k < n; k++)
      begin
         exp_q.push_back(mem[cnt]);
         cnt++;
         m.rb(k == n - 1, d);
      end
      m.edge_cond(1'b0);
      cmp("counter", addr_cnt, cnt);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(m.got)
      cmp("data", m.o_rd_data, exp_q.pop_front());
   initial
   begin
      repeat (60000) @(posedge i_clk);
      mismatches++;
      finish_test();
   end
   initial
   begin
      @(posedge i_clk);
      sel <= rnd[2:0];
      i_ld_data <= rnd[10:3];
      repeat (19) @(posedge i_clk);
      rnd = xs(rnd);
      sel <= rnd[2:0];
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (int k = 0; k < 8208; k++)
      begin
         if (k == 8192)
         begin
            i_ld_valid <= 1'b0;
            repeat (40) @(posedge i_clk);
            i_write_busy <= 1'b1;
         end
         rnd = xs(rnd);
         push(rnd[7:0]);
      end
      i_ld_valid <= 1'b0;
      repeat (3) @(posedge i_clk);
      cmp("ld ready", ld_ready, 1'b0);
      m.edge_cond(1'b1);
      m.wb({DEV, sel, 1'b1}, s);
      cmp("busy ack", s, 1'b1);
      m.edge_cond(1'b0);
      i_write_busy <= 1'b0;
      repeat (40) @(posedge i_clk);
      $display("test fill done");
      rd(1);
      rd(1);
      $display("test current done");
      seek(8'h0a, 8'h55);
      rd(4);
      $display("test random done");
      seek(8'h1f, 8'hfe);
      rd(3);
      $display("test wrap done");
      m.edge_cond(1'b1);
      m.wb({DEV, sel ^ 3'h4, 1'b1}, s);
      cmp("sel ack", s, 1'b1);
      m.edge_cond(1'b0);
      sel <= sel ^ 3'h4;
      repeat (4) @(posedge i_clk);
      rd(1);
      $display("test select done");
      finish_test();
   end
endmodule
